// File: include/dic_pkg.sv
package dic_pkg;
    // -------------------------------------------------------------------
    // Channel count and clocking
    // -------------------------------------------------------------------
    localparam int CH_N      = 16;
    localparam int CLK_HZ    = 40_000_000;
    localparam int MS_PER_S  = 1000;
    localparam int MS_CYCLES = CLK_HZ / MS_PER_S;
    localparam int TICK_W    = 16;

    // -------------------------------------------------------------------
    // Register map, byte addresses on a 32-bit word bus
    // -------------------------------------------------------------------
    localparam int          ADDR_W       = 8;
    localparam logic [7:0]  OFS_POL      = 8'h00;
    localparam logic [7:0]  OFS_NC       = 8'h04;
    localparam logic [7:0]  OFS_FILT     = 8'h08;
    localparam logic [7:0]  OFS_PERS     = 8'h0c;
    localparam logic [7:0]  OFS_IMAGE    = 8'h10;
    localparam logic [7:0]  OFS_RAW      = 8'h14;
    localparam logic [15:0] RST_POL      = 16'h0000;
    localparam logic [15:0] RST_NC       = 16'h0000;
    localparam logic [31:0] RST_FILT     = 32'h0000_0000;
    localparam logic [31:0] RST_PERS     = 32'h0000_0000;
    localparam logic [1:0]  RESP_OKAY    = 2'h0;
    localparam logic [1:0]  RESP_SLVERR  = 2'h2;

    // -------------------------------------------------------------------
    // Per-channel selector codes, two bits per channel
    // -------------------------------------------------------------------
    localparam logic [1:0] FSEL_3MS   = 2'h0;
    localparam logic [1:0] FSEL_10MS  = 2'h1;
    localparam logic [1:0] FSEL_20MS  = 2'h2;
    localparam logic [1:0] FSEL_OFF   = 2'h3;
    localparam logic [1:0] PSEL_OFF   = 2'h0;
    localparam logic [1:0] PSEL_15MS  = 2'h1;
    localparam logic [1:0] PSEL_50MS  = 2'h2;
    localparam logic [1:0] PSEL_100MS = 2'h3;

    // -------------------------------------------------------------------
    // Times in ms and their counts in ms ticks
    // -------------------------------------------------------------------
    // One extra tick makes each least time hold whatever the tick phase.
    localparam int          CNT_W      = 7;
    localparam logic [6:0]  FILT_3_MS  = 7'h03;
    localparam logic [6:0]  FILT_10_MS = 7'h0a;
    localparam logic [6:0]  FILT_20_MS = 7'h14;
    localparam logic [6:0]  PERS_15_MS = 7'h0f;
    localparam logic [6:0]  PERS_50_MS = 7'h32;
    localparam logic [6:0]  PERS_100_MS = 7'h64;
    localparam logic [6:0]  TICK_MARGIN = 7'h01;
endpackage

// File: tb/dic_coupler_model.sv
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------------------------
// Coupler scan of the conditioned input image.
// ---------------------------------------------------------------
module dic_coupler_model
    import dic_pkg::*;
(
    input  wire logic                     clk,    // Scan clock.
    input  wire logic                     rst_n,  // Reset, active low.
    input  wire logic [dic_pkg::CH_N-1:0] image,  // Image from the module.
    input  wire logic                     clr,    // Clears the sticky capture.
    output logic      [dic_pkg::CH_N-1:0] seen,   // Channels seen true since clear.
    output logic      [15:0]              hi_len  // Last true run length, channel 0.
);
    logic [15:0] run_q;
    // Scanning every cycle is harsher than a real network scan: any glitch is caught.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            seen <= '0;
            run_q <= '0;
            hi_len <= '0;
        end else begin
            seen <= clr ? '0 : (seen | image);
            run_q <= image[0] ? run_q + 16'h0001 : 16'h0000;
            if (!image[0] && run_q != 16'h0000) begin
                hi_len <= run_q;
            end
        end
    end
endmodule
`default_nettype wire

// File: tb/dic_top_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin mismatches++; \
    $display("[ERR] t=%0t got %h exp %h", $time, a, b); end end
// ---------------------------------------------------------------
// Register access and pin stimulus.
// ---------------------------------------------------------------
module dic_top_tb_top;
    import dic_pkg::*;
    localparam int TK = 4;
    logic CLK = 1'b0, RST_N = 1'b0, clr = 1'b0;
    logic [15:0] IN_PINS = '0, IN_IMAGE, seen, hi_len;
    logic [7:0] AWADDR = '0, ARADDR = '0;
    logic [31:0] WDATA = '0, RDATA;
    logic [3:0] WSTRB = '0;
    logic AWVALID = 0, WVALID = 0, BREADY = 0, ARVALID = 0, RREADY = 0;
    logic AWREADY, WREADY, BVALID, ARREADY, RVALID;
    logic [1:0] BRESP, RRESP;
    int mismatches = 0, tests_run = 0;
    int fn[3] = '{3, 10, 20};
    int pn[3] = '{15, 50, 100};

    dic_top #(.MS_TICK_CYCLES(TK)) dic_top_inst (.CLK(CLK), .RST_N(RST_N),
        .IN_PINS(IN_PINS), .IN_IMAGE(IN_IMAGE), .AWADDR(AWADDR), .AWVALID(AWVALID),
        .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID),
        .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY),
        .ARADDR(ARADDR), .ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA),
        .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY));
    dic_coupler_model dic_coupler_model_inst (.clk(CLK), .rst_n(RST_N),
        .image(IN_IMAGE), .clr(clr), .seen(seen), .hi_len(hi_len));

    initial begin
        forever #12.5 CLK = ~CLK;
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge CLK);
    endtask

    // Tasks are entered just after a rising edge, so ready reads its pre-edge value.
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                      input logic [1:0] er);
        logic aw, w;
        int n;
        aw = 1'b1;
        w = 1'b1;
        n = 0;
        AWADDR <= a;
        WDATA <= d;
        WSTRB <= s;
        AWVALID <= 1'b1;
        WVALID <= 1'b1;
        while ((aw || w) && n < 200) begin
            @(posedge CLK);
            n++;
            if (aw && AWREADY) begin
                AWVALID <= 1'b0;
                aw = 1'b0;
            end
            if (w && WREADY) begin
                WVALID <= 1'b0;
                w = 1'b0;
            end
        end
        // Raised only once both halves are taken, so a back-to-back call never
        // lowers and raises it in one time step.
        BREADY <= 1'b1;
        do begin
            @(posedge CLK);
            n++;
        end while (!BVALID && n < 400);
        BREADY <= 1'b0;
        `CHK({BVALID, BRESP}, {1'b1, er})
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        int n;
        n = 0;
        ARADDR <= a;
        ARVALID <= 1'b1;
        do begin
            @(posedge CLK);
            n++;
        end while (!ARREADY && n < 200);
        ARVALID <= 1'b0;
        RREADY <= 1'b1;
        do begin
            @(posedge CLK);
            n++;
        end while (!RVALID && n < 400);
        RREADY <= 1'b0;
        `CHK(RDATA, ed)
        `CHK({RVALID, RRESP}, {1'b1, er})
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    initial begin
        #2_000_000;
        mismatches++;
        end_sim();
    end

    initial begin
        cyc(5);
        RST_N <= 1'b1;
        cyc(3);
        for (int i = 0; i < 4; i++) rd_chk(8'(4 * i), 32'h0, RESP_OKAY);
        rd_chk(8'h20, 32'h0, RESP_SLVERR);
        wr(OFS_IMAGE, 32'hffff_ffff, 4'hf, RESP_SLVERR);
        wr(OFS_FILT, 32'hffff_ffff, 4'h1, RESP_OKAY);
        rd_chk(OFS_FILT, 32'h0000_00ff, RESP_OKAY);
        wr(OFS_FILT, 32'hffff_ffff, 4'hf, RESP_OKAY);
        $display("test registers done");
        IN_PINS <= 16'h00a5;
        cyc(4);
        `CHK(IN_IMAGE, 16'h0000)
        cyc(1);
        `CHK(IN_IMAGE, 16'h00a5)
        IN_PINS <= 16'h0000;
        cyc(4);
        `CHK(IN_IMAGE, 16'h00a5)
        cyc(1);
        `CHK(IN_IMAGE, 16'h0000)
        $display("test passthrough done");
        wr(OFS_POL, 32'hffff_000a, 4'hf, RESP_OKAY);
        rd_chk(OFS_POL, 32'h0000_000a, RESP_OKAY);
        wr(OFS_NC, 32'h0000_000c, 4'hf, RESP_OKAY);
        cyc(8);
        `CHK(IN_IMAGE, 16'h0006)
        IN_PINS <= 16'hffff;
        cyc(8);
        `CHK(IN_IMAGE, 16'hfff9)
        rd_chk(OFS_RAW, 32'h0000_ffff, RESP_OKAY);
        wr(OFS_POL, 32'h0, 4'hf, RESP_OKAY);
        wr(OFS_NC, 32'h0, 4'hf, RESP_OKAY);
        IN_PINS <= 16'h0000;
        $display("test polarity done");
        for (int i = 0; i < 3; i++) begin
            wr(OFS_FILT, 32'hffff_fffc | 32'(i), 4'hf, RESP_OKAY);
            cyc(fn[i] * TK + 16);
            clr <= 1'b1;
            cyc(1);
            clr <= 1'b0;
            IN_PINS <= 16'h0001;
            cyc(fn[i] * TK - 1);
            IN_PINS <= 16'h0000;
            cyc(fn[i] * TK + 16);
            `CHK(seen[0], 1'b0)
            IN_PINS <= 16'h0001;
            cyc(fn[i] * TK);
            `CHK(IN_IMAGE[0], 1'b0)
            cyc(16);
            `CHK(IN_IMAGE[0], 1'b1)
            IN_PINS <= 16'h0000;
            cyc(fn[i] * TK + 16);
            `CHK(IN_IMAGE[0], 1'b0)
        end
        $display("test filter done");
        wr(OFS_FILT, 32'hffff_ffff, 4'hf, RESP_OKAY);
        for (int i = 0; i < 3; i++) begin
            wr(OFS_PERS, 32'(i + 1), 4'hf, RESP_OKAY);
            IN_PINS <= 16'h0001;
            cyc(8);
            IN_PINS <= 16'h0000;
            cyc(pn[i] * TK + 20);
            `CHK(hi_len >= 16'(pn[i] * TK) && hi_len <= 16'(pn[i] * TK + 12), 1'b1)
            `CHK(IN_IMAGE[0], 1'b0)
        end
        $display("test persistence done");
        end_sim();
    end
endmodule
`default_nettype wire

// File: verilog/dic_chan.sv
`timescale 1ns/1ps
`default_nettype none
module dic_chan
    import dic_pkg::*;
(
    input  wire logic       clk,      // Module clock.
    input  wire logic       rst_n,    // Asynchronous reset, active low.
    input  wire logic       tick,     // One-cycle ms tick.
    input  wire logic       pin,      // Synchronised pin level.
    input  wire logic       sink,     // 1 selects sinking polarity.
    input  wire logic       nc,       // 1 selects normally closed.
    input  wire logic [1:0] fsel,     // Filter time code.
    input  wire logic [1:0] psel,     // Persistence time code.
    output logic            img       // Conditioned value.
);
    // -------------------------------------------------------------------
    // Polarity, operating state, thresholds
    // -------------------------------------------------------------------
    wire       present = sink ? ~pin : pin;
    wire       act     = present ^ nc;
    wire [6:0] fthr    = (fsel == FSEL_10MS) ? FILT_10_MS + TICK_MARGIN :
                         (fsel == FSEL_20MS) ? FILT_20_MS + TICK_MARGIN :
                                               FILT_3_MS + TICK_MARGIN;
    wire [6:0] pthr    = (psel == PSEL_15MS) ? PERS_15_MS + TICK_MARGIN :
                         (psel == PSEL_50MS) ? PERS_50_MS + TICK_MARGIN :
                                               PERS_100_MS + TICK_MARGIN;
    wire       f_off   = (fsel == FSEL_OFF);
    wire       p_off   = (psel == PSEL_OFF);

    logic       filt_q, filt_d;
    logic [6:0] fcnt_q, fcnt_d;
    logic [6:0] hcnt_q, hcnt_d;
    logic       img_q;

    // -------------------------------------------------------------------
    // Duration filter, then persistence stretcher
    // -------------------------------------------------------------------
    always_comb begin
        filt_d = filt_q;
        fcnt_d = fcnt_q;
        if (f_off) begin
            filt_d = act;
            fcnt_d = 7'h00;
        end else if (act == filt_q) begin
            fcnt_d = 7'h00;
        end else if (tick) begin
            if (fcnt_q + 7'h01 >= fthr) begin
                filt_d = act;
                fcnt_d = 7'h00;
            end else begin
                fcnt_d = fcnt_q + 7'h01;
            end
        end
        hcnt_d = hcnt_q;
        if (p_off) begin
            hcnt_d = 7'h00;
        end else if (filt_d && !filt_q) begin
            hcnt_d = pthr;
        end else if (tick && hcnt_q != 7'h00) begin
            hcnt_d = hcnt_q - 7'h01;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            filt_q <= 1'b0;
            fcnt_q <= 7'h00;
            hcnt_q <= 7'h00;
            img_q  <= 1'b0;
        end else begin
            filt_q <= filt_d;
            fcnt_q <= fcnt_d;
            hcnt_q <= hcnt_d;
            img_q  <= filt_d | (hcnt_d != 7'h00);
        end
    end

    assign img = img_q;

    // -------------------------------------------------------------------
    // Checks
    // -------------------------------------------------------------------
    a_filter_off_pass: assert property (@(posedge clk) disable iff (!rst_n)
        f_off && p_off |=> img_q == $past(act))
        else $error("unfiltered channel does not follow its input");
    a_filter_no_early: assert property (@(posedge clk) disable iff (!rst_n)
        !f_off && !tick |=> filt_q == $past(filt_q))
        else $error("filtered value changed without a ms tick");
    a_persist_load: assert property (@(posedge clk) disable iff (!rst_n)
        !p_off && filt_d && !filt_q |=> hcnt_q == $past(pthr) && img_q)
        else $error("persistence not loaded on a rising value");
    a_persist_off: assert property (@(posedge clk) disable iff (!rst_n)
        p_off |=> hcnt_q == 7'h00 && img_q == $past(filt_d))
        else $error("stretching while persistence is off");
endmodule
`default_nettype wire

// File: verilog/dic_top.sv
// Operation
// - Sixteen channels, each with its own polarity, state, filter and persistence.
// - Sourcing polarity, the reset default, means active at positive supply.
// - Sinking polarity means active when the pin sits at zero volts.
// - Normally open reports signal present; normally closed reports signal absent.
// - Persistence 15, 50 or 100 ms holds a true value at least that long.
// - Persistence off, the default, reports true only while the signal is true.
// - Filter 3, 10 or 20 ms rejects shorter pulses and delays acceptance.
// - Filter off passes the signal with no minimum duration.
`timescale 1ns/1ps
`default_nettype none
module dic_top
    import dic_pkg::*;
#(
    parameter int MS_TICK_CYCLES = dic_pkg::MS_CYCLES  // Clock cycles per ms.
)(
    input  wire logic                      CLK,      // 40 MHz module clock.
    input  wire logic                      RST_N,    // Asynchronous reset, active low.
    input  wire logic [dic_pkg::CH_N-1:0]  IN_PINS,  // Raw terminal levels.
    output logic      [dic_pkg::CH_N-1:0]  IN_IMAGE, // Conditioned image to coupler.
    input  wire logic [dic_pkg::ADDR_W-1:0] AWADDR,  // Write address.
    input  wire logic                      AWVALID,  // Write address valid.
    output logic                           AWREADY,  // Write address ready.
    input  wire logic [31:0]               WDATA,    // Write data.
    input  wire logic [3:0]                WSTRB,    // Write byte enables.
    input  wire logic                      WVALID,   // Write data valid.
    output logic                           WREADY,   // Write data ready.
    output logic [1:0]                     BRESP,    // Write response.
    output logic                           BVALID,   // Write response valid.
    input  wire logic                      BREADY,   // Write response ready.
    input  wire logic [dic_pkg::ADDR_W-1:0] ARADDR,  // Read address.
    input  wire logic                      ARVALID,  // Read address valid.
    output logic                           ARREADY,  // Read address ready.
    output logic [31:0]                    RDATA,    // Read data.
    output logic [1:0]                     RRESP,    // Read response.
    output logic                           RVALID,   // Read data valid.
    input  wire logic                      RREADY    // Read data ready.
);
    // -------------------------------------------------------------------
    // Pin synchroniser and ms tick
    // -------------------------------------------------------------------
    logic [CH_N-1:0]   pin_m_q, pin_s_q;
    logic [TICK_W-1:0] tcnt_q;
    logic              tick_q;
    wire               tcnt_end = (tcnt_q == TICK_W'(MS_TICK_CYCLES - 1));

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            pin_m_q <= '0;
            pin_s_q <= '0;
        end else begin
            pin_m_q <= IN_PINS;
            pin_s_q <= pin_m_q;
        end
    end

    // Every channel shares this one tick, so all timers run in step.
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            tcnt_q <= '0;
            tick_q <= 1'b0;
        end else begin
            tcnt_q <= tcnt_end ? '0 : tcnt_q + TICK_W'(1);
            tick_q <= tcnt_end;
        end
    end

    // -------------------------------------------------------------------
    // Configuration registers
    // -------------------------------------------------------------------
    logic [CH_N-1:0]   pol_q, nc_q;
    logic [2*CH_N-1:0] filt_q, pers_q;
    logic [CH_N-1:0]   img_w;
    logic [CH_N-1:0]   img_q;

    // -------------------------------------------------------------------
    // Write channel
    // -------------------------------------------------------------------
    logic [ADDR_W-1:0] awaddr_q;
    logic [31:0]       wdata_q;
    logic [3:0]        wstrb_q;
    logic              aw_have_q, w_have_q, bvalid_q, awready_q, wready_q;
    logic [1:0]        bresp_q;

    wire aw_take   = AWVALID && awready_q;
    wire w_take    = WVALID && wready_q;
    wire aw_have_d = aw_have_q || aw_take;
    wire w_have_d  = w_have_q || w_take;
    wire [ADDR_W-1:0] wa    = aw_take ? AWADDR : awaddr_q;
    wire [31:0]       wd    = w_take ? WDATA : wdata_q;
    wire [3:0]        ws    = w_take ? WSTRB : wstrb_q;
    wire              do_wr = aw_have_d && w_have_d && !bvalid_q;
    wire              wr_ok = (wa == OFS_POL) || (wa == OFS_NC) ||
                              (wa == OFS_FILT) || (wa == OFS_PERS);
    wire [31:0]       wmask = {{8{ws[3]}}, {8{ws[2]}}, {8{ws[1]}}, {8{ws[0]}}};
    wire              bvalid_d = do_wr || (bvalid_q && !BREADY);

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [31:0] m);
        merge = (old & ~m) | (nw & m);
    endfunction

    // The narrow registers are widened for the merge and cut back to 16 bits on store.
    wire [31:0]       pol_wr = merge({16'h0000, pol_q}, wd, wmask);
    wire [31:0]       nc_wr  = merge({16'h0000, nc_q}, wd, wmask);

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            awaddr_q  <= '0;
            wdata_q   <= '0;
            wstrb_q   <= '0;
            aw_have_q <= 1'b0;
            w_have_q  <= 1'b0;
            awready_q <= 1'b0;
            wready_q  <= 1'b0;
            bvalid_q  <= 1'b0;
            bresp_q   <= RESP_OKAY;
        end else begin
            if (aw_take) awaddr_q <= AWADDR;
            if (w_take) begin
                wdata_q <= WDATA;
                wstrb_q <= WSTRB;
            end
            aw_have_q <= aw_have_d && !do_wr;
            w_have_q  <= w_have_d && !do_wr;
            awready_q <= !(aw_have_d && !do_wr) && !bvalid_d;
            wready_q  <= !(w_have_d && !do_wr) && !bvalid_d;
            bvalid_q  <= bvalid_d;
            if (do_wr) bresp_q <= wr_ok ? RESP_OKAY : RESP_SLVERR;
        end
    end

    // Each channel owns its own bits, so a write never disturbs a neighbour.
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            pol_q  <= RST_POL;
            nc_q   <= RST_NC;
            filt_q <= RST_FILT;
            pers_q <= RST_PERS;
        end else if (do_wr) begin
            if (wa == OFS_POL)  pol_q  <= pol_wr[15:0];
            if (wa == OFS_NC)   nc_q   <= nc_wr[15:0];
            if (wa == OFS_FILT) filt_q <= merge(filt_q, wd, wmask);
            if (wa == OFS_PERS) pers_q <= merge(pers_q, wd, wmask);
        end
    end

    // -------------------------------------------------------------------
    // Read channel
    // -------------------------------------------------------------------
    logic        rvalid_q, arready_q;
    logic [31:0] rdata_q;
    logic [1:0]  rresp_q;

    wire ar_take = ARVALID && arready_q;
    wire rd_ok   = (ARADDR == OFS_POL) || (ARADDR == OFS_NC) || (ARADDR == OFS_FILT) ||
                   (ARADDR == OFS_PERS) || (ARADDR == OFS_IMAGE) || (ARADDR == OFS_RAW);
    wire [31:0] rd_mux =
        (ARADDR == OFS_POL)   ? {16'h0000, pol_q} :
        (ARADDR == OFS_NC)    ? {16'h0000, nc_q} :
        (ARADDR == OFS_FILT)  ? filt_q :
        (ARADDR == OFS_PERS)  ? pers_q :
        (ARADDR == OFS_IMAGE) ? {16'h0000, img_q} :
        (ARADDR == OFS_RAW)   ? {16'h0000, pin_s_q} : 32'h0000_0000;
    wire rvalid_d = ar_take || (rvalid_q && !RREADY);

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            rvalid_q  <= 1'b0;
            arready_q <= 1'b0;
            rdata_q   <= '0;
            rresp_q   <= RESP_OKAY;
        end else begin
            rvalid_q  <= rvalid_d;
            arready_q <= !rvalid_d;
            if (ar_take) begin
                rdata_q <= rd_mux;
                rresp_q <= rd_ok ? RESP_OKAY : RESP_SLVERR;
            end
        end
    end

    // -------------------------------------------------------------------
    // Channels
    // -------------------------------------------------------------------
    for (genvar i = 0; i < CH_N; i++) begin : g_ch
        dic_chan u_ch (
            .clk   (CLK),
            .rst_n (RST_N),
            .tick  (tick_q),
            .pin   (pin_s_q[i]),
            .sink  (pol_q[i]),
            .nc    (nc_q[i]),
            .fsel  (filt_q[2*i +: 2]),
            .psel  (pers_q[2*i +: 2]),
            .img   (img_w[i])
        );
    end

    // The channel outputs are flops already; this copy is the image register.
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) img_q <= '0;
        else        img_q <= img_w;
    end

    assign IN_IMAGE = img_q;
    assign AWREADY  = awready_q;
    assign WREADY   = wready_q;
    assign BVALID   = bvalid_q;
    assign BRESP    = bresp_q;
    assign ARREADY  = arready_q;
    assign RVALID   = rvalid_q;
    assign RDATA    = rdata_q;
    assign RRESP    = rresp_q;

    // -------------------------------------------------------------------
    // Checks
    // -------------------------------------------------------------------
    a_tick_single: assert property (@(posedge CLK) disable iff (!RST_N)
        tick_q |=> !tick_q || MS_TICK_CYCLES == 1)
        else $error("ms tick lasted longer than one cycle");
    a_cfg_write: assert property (@(posedge CLK) disable iff (!RST_N)
        do_wr && wa == OFS_POL && ws == 4'hf |=> pol_q == $past(wd[15:0]) && nc_q == $past(nc_q))
        else $error("polarity write lost or spilled into another register");
    a_bresp_hold: assert property (@(posedge CLK) disable iff (!RST_N)
        BVALID && !BREADY |=> BVALID && $stable(BRESP))
        else $error("write response dropped before it was taken");
    a_rdata_hold: assert property (@(posedge CLK) disable iff (!RST_N)
        RVALID && !RREADY |=> RVALID && $stable(RDATA))
        else $error("read data changed before it was taken");
endmodule
`default_nettype wire
